// ==== rtl/oft_clk_ctrl.sv ====
// Operation
// (RQ1) Low-frequency oscillator runs only while its enable bit 7 is one.
// (RQ2) Read-only bit 6 reads one once the oscillator has settled.
// (RQ3) Trim bits 5..2 tune speed: 0000b fastest, 1111b slowest.
// (RQ4) Divider field: 00 by 8, 01 by 4, 10 by 2, 11 by 1.
// (RQ5) External oscillator mode 010 selects the CMOS clock input.
// (RQ6) One-shot off: sense amps on whole read; on: short pulse.
// (RQ7) Software keeps one-shot on below 10 MHz to save power.
// (RQ8) Read-time bit 4: zero short timing to 25 MHz, one to 48 MHz.
// (RQ9) Stop halts CPU and oscillator; idle gates CPU; both read zero.
// (RQ10) Crystal-valid reads one only in crystal mode with stable crystal.
//
// Chosen here: register access over AXI4-Lite.
module oft_clk_ctrl (
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  input  wire oft_pkg::oft_axi_req_t axiReq,
  output oft_pkg::oft_axi_rsp_t     axiRsp,
  input  wire logic                 xtalStable,
  input  wire logic                 wakeReq,
  input  wire logic                 flashRdReq,
  output logic                      irq,
  output logic                      cpuClkEn,
  output logic                      intOscRun,
  output logic                      lfTick,
  output logic [3:0]                lfTrim,
  output logic                      extCmosMode,
  output logic [2:0]                extDriveSel,
  output logic                      flashSenseEn,
  output logic                      flashRdBusy,
  output logic                      flashRdDone
);

  typedef enum logic [1:0] {PwRun, PwIdle, PwStop} oft_pwr_t;

  // Register contents.
  logic        lfEn_q, lfEn_d;
  logic [3:0]  trim_q, trim_d;
  logic [1:0]  div_q, div_d;
  logic [5:0]  flags_q, flags_d;
  logic [2:0]  xMode_q, xMode_d;
  logic [2:0]  xDrv_q, xDrv_d;
  logic        oneShot_q, oneShot_d;
  logic        rdTime_q, rdTime_d;
  logic [2:0]  stat_q, stat_d;
  logic [2:0]  mask_q, mask_d;
  oft_pwr_t    pwr_q, pwr_d;

  // Bus state.
  logic              awHeld_q, awHeld_d;
  logic [7:0]        awIdx_q, awIdx_d;
  logic              wHeld_q, wHeld_d;
  logic [7:0]        wData_q, wData_d;
  logic              wLane_q, wLane_d;
  logic              bValid_q, bValid_d;
  logic [1:0]        bResp_q, bResp_d;
  logic              rValid_q, rValid_d;
  logic [31:0]       rData_q, rData_d;
  logic [1:0]        rResp_q, rResp_d;

  // Synchroniser and edge history.
  logic        xtalMeta_q, xtalSync_q;
  logic        lfRdyOld_q, xtalOkOld_q;

  logic        lfReady;
  logic        xtalOk;
  logic        doWrite;
  logic [7:0]  wrIdx;
  logic [7:0]  rdIdx;
  logic [7:0]  rdByte;
  logic        rdHit;
  logic [2:0]  events;

  // The crystal status comes from the pad, so it crosses two flops first.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      xtalMeta_q <= 1'b0;
      xtalSync_q <= 1'b0;
    end else begin
      xtalMeta_q <= xtalStable;
      xtalSync_q <= xtalMeta_q;
    end
  end

  oft_lf_osc u_lf_osc (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .enable  (lfEn_q),
    .trim    (trim_q),
    .divSel  (div_q),
    .ready   (lfReady),
    .lfTick  (lfTick)
  );

  // Software must pick the smallest read time allowed for its clock rate.
  oft_flash_rd u_flash_rd (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .rdReq     (flashRdReq),
    .oneShotEn (oneShot_q),
    .longRead  (rdTime_q),
    .senseEn   (flashSenseEn),
    .rdBusy    (flashRdBusy),
    .rdDone    (flashRdDone)
  );

  // Crystal valid is masked outside the crystal modes.
  assign xtalOk = (xMode_q[2:1] == oft_pkg::XO_MODE_XTAL)   // see (RQ10)
                  && xtalSync_q;
  assign extCmosMode = (xMode_q == oft_pkg::XO_MODE_CMOS);  // see (RQ5)
  assign extDriveSel = xDrv_q;
  assign lfTrim      = trim_q;
  assign cpuClkEn    = (pwr_q == PwRun);                    // see (RQ9)
  assign intOscRun   = (pwr_q != PwStop);                   // see (RQ9)
  assign irq         = |(stat_q & mask_q);

  // Bus handshakes; each write channel is taken once and held until used.
  assign axiRsp.awready = !awHeld_q && !bValid_q;
  assign axiRsp.wready  = !wHeld_q && !bValid_q;
  assign axiRsp.bvalid  = bValid_q;
  assign axiRsp.bresp   = bResp_q;
  assign axiRsp.arready = !rValid_q;
  assign axiRsp.rvalid  = rValid_q;
  assign axiRsp.rdata   = rData_q;
  assign axiRsp.rresp   = rResp_q;

  assign doWrite = awHeld_q && wHeld_q && !bValid_q;
  assign wrIdx   = awIdx_q;
  assign rdIdx   = axiReq.araddr[9:2];

  // Read mux; reserved bits and write-only strobes read as zero.
  always_comb begin
    rdHit  = 1'b1;
    rdByte = 8'h00;
    unique case (rdIdx)
      oft_pkg::IDX_LF_OSC:   rdByte = {lfEn_q, lfReady, trim_q, div_q};
      oft_pkg::IDX_PWR:      rdByte = {flags_q, 2'h0};
      oft_pkg::IDX_EXT_OSC:  rdByte = {xtalOk, xMode_q, 1'b0, xDrv_q};
      oft_pkg::IDX_FL_SCALE: rdByte = {oneShot_q, 2'h0, rdTime_q, 4'h0};
      oft_pkg::IDX_IRQ_STAT: rdByte = {5'h00, stat_q};
      oft_pkg::IDX_IRQ_MASK: rdByte = {5'h00, mask_q};
      default:               rdHit  = 1'b0;
    endcase
    if (axiReq.araddr[11:10] != 2'h0 || axiReq.araddr[1:0] != 2'h0) begin
      rdHit = 1'b0;
    end
  end

  // Bus channel state.
  always_comb begin
    awHeld_d = awHeld_q;
    awIdx_d  = awIdx_q;
    wHeld_d  = wHeld_q;
    wData_d  = wData_q;
    wLane_d  = wLane_q;
    bValid_d = bValid_q;
    bResp_d  = bResp_q;
    rValid_d = rValid_q;
    rData_d  = rData_q;
    rResp_d  = rResp_q;
    if (axiReq.awvalid && axiRsp.awready) begin
      awHeld_d = 1'b1;
      awIdx_d  = (axiReq.awaddr[11:10] == 2'h0 &&
                  axiReq.awaddr[1:0] == 2'h0) ? axiReq.awaddr[9:2] : 8'h00;
    end
    if (axiReq.wvalid && axiRsp.wready) begin
      wHeld_d = 1'b1;
      wData_d = axiReq.wdata[7:0];
      wLane_d = axiReq.wstrb[0];
    end
    if (doWrite) begin
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
      bValid_d = 1'b1;
      bResp_d  = (wrIdx == oft_pkg::IDX_LF_OSC ||
                  wrIdx == oft_pkg::IDX_PWR ||
                  wrIdx == oft_pkg::IDX_EXT_OSC ||
                  wrIdx == oft_pkg::IDX_FL_SCALE ||
                  wrIdx == oft_pkg::IDX_IRQ_STAT ||
                  wrIdx == oft_pkg::IDX_IRQ_MASK) ?
                 oft_pkg::RESP_OKAY : oft_pkg::RESP_SLVERR;
    end else if (bValid_q && axiReq.bready) begin
      bValid_d = 1'b0;
    end
    if (axiReq.arvalid && axiRsp.arready) begin
      rValid_d = 1'b1;
      rData_d  = {24'h000000, rdByte};
      rResp_d  = rdHit ? oft_pkg::RESP_OKAY : oft_pkg::RESP_SLVERR;
    end else if (rValid_q && axiReq.rready) begin
      rValid_d = 1'b0;
    end
  end

  // Hardware events: ready rising, crystal valid rising, wake from sleep.
  assign events = {(pwr_q != PwRun) && wakeReq,
                   xtalOk && !xtalOkOld_q,
                   lfReady && !lfRdyOld_q};

  // Register file, power state and interrupt flags.
  always_comb begin
    lfEn_d    = lfEn_q;
    trim_d    = trim_q;
    div_d     = div_q;
    flags_d   = flags_q;
    xMode_d   = xMode_q;
    xDrv_d    = xDrv_q;
    oneShot_d = oneShot_q;
    rdTime_d  = rdTime_q;
    mask_d    = mask_q;
    pwr_d     = pwr_q;
    stat_d    = stat_q;
    // A wake request returns the CPU from either low-power state.
    if (pwr_q != PwRun && wakeReq) begin
      pwr_d = PwRun;
    end
    if (doWrite && wLane_q) begin
      unique case (wrIdx)
        oft_pkg::IDX_LF_OSC: begin
          lfEn_d = wData_q[oft_pkg::LF_EN_BIT];             // see (RQ1)
          trim_d = wData_q[oft_pkg::LF_TRIM_LSB +: 4];      // see (RQ3)
          div_d  = wData_q[oft_pkg::LF_DIV_LSB +: 2];       // see (RQ4)
        end
        oft_pkg::IDX_PWR: begin
          flags_d = wData_q[oft_pkg::PWR_FLAG_LSB +: 6];
          // Stop outranks idle when both are written together.
          if (wData_q[oft_pkg::PWR_STOP_BIT]) begin
            pwr_d = PwStop;                                 // see (RQ9)
          end else if (wData_q[oft_pkg::PWR_IDLE_BIT]) begin
            pwr_d = PwIdle;                                 // see (RQ9)
          end
        end
        oft_pkg::IDX_EXT_OSC: begin
          xMode_d = wData_q[oft_pkg::XO_MODE_LSB +: 3];     // see (RQ5)
          xDrv_d  = wData_q[oft_pkg::XO_DRV_LSB +: 3];
        end
        oft_pkg::IDX_FL_SCALE: begin
          oneShot_d = wData_q[oft_pkg::FL_ONESHOT_BIT];     // see (RQ6)
          rdTime_d  = wData_q[oft_pkg::FL_RDTIME_BIT];      // see (RQ8)
        end
        oft_pkg::IDX_IRQ_STAT: stat_d = stat_q & ~wData_q[2:0];
        oft_pkg::IDX_IRQ_MASK: mask_d = wData_q[2:0];
        default: ;
      endcase
    end
    // A new event beats a clear written in the same cycle.
    stat_d = stat_d | events;
  end

  // Registers only.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lfEn_q      <= 1'b0;
      trim_q      <= oft_pkg::LF_TRIM_RST;
      div_q       <= 2'h0;
      flags_q     <= oft_pkg::PWR_FLAG_RST;
      xMode_q     <= oft_pkg::EXT_OSC_RST[6:4];
      xDrv_q      <= oft_pkg::EXT_OSC_RST[2:0];
      oneShot_q   <= oft_pkg::FL_SCALE_RST[7];
      rdTime_q    <= oft_pkg::FL_SCALE_RST[4];
      stat_q      <= 3'h0;
      mask_q      <= oft_pkg::IRQ_MASK_RST;
      pwr_q       <= PwRun;
      awHeld_q    <= 1'b0;
      awIdx_q     <= 8'h00;
      wHeld_q     <= 1'b0;
      wData_q     <= 8'h00;
      wLane_q     <= 1'b0;
      bValid_q    <= 1'b0;
      bResp_q     <= 2'h0;
      rValid_q    <= 1'b0;
      rData_q     <= 32'h00000000;
      rResp_q     <= 2'h0;
      lfRdyOld_q  <= 1'b0;
      xtalOkOld_q <= 1'b0;
    end else begin
      lfEn_q      <= lfEn_d;
      trim_q      <= trim_d;
      div_q       <= div_d;
      flags_q     <= flags_d;
      xMode_q     <= xMode_d;
      xDrv_q      <= xDrv_d;
      oneShot_q   <= oneShot_d;
      rdTime_q    <= rdTime_d;
      stat_q      <= stat_d;
      mask_q      <= mask_d;
      pwr_q       <= pwr_d;
      awHeld_q    <= awHeld_d;
      awIdx_q     <= awIdx_d;
      wHeld_q     <= wHeld_d;
      wData_q     <= wData_d;
      wLane_q     <= wLane_d;
      bValid_q    <= bValid_d;
      bResp_q     <= bResp_d;
      rValid_q    <= rValid_d;
      rData_q     <= rData_d;
      rResp_q     <= rResp_d;
      lfRdyOld_q  <= lfReady;
      xtalOkOld_q <= xtalOk;
    end
  end

endmodule // oft_clk_ctrl

// ==== rtl/oft_pkg.sv ====
package oft_pkg;

  // Register bus geometry.
  localparam int          ADDR_W        = 12;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0]  IDX_LF_OSC    = 8'h86;
  localparam logic [7:0]  IDX_PWR       = 8'h87;
  localparam logic [7:0]  IDX_EXT_OSC   = 8'hB1;
  localparam logic [7:0]  IDX_FL_SCALE  = 8'hB6;
  localparam logic [7:0]  IDX_IRQ_STAT  = 8'hC0;
  localparam logic [7:0]  IDX_IRQ_MASK  = 8'hC1;

  // Field positions.
  localparam int          LF_EN_BIT     = 7;
  localparam int          LF_RDY_BIT    = 6;
  localparam int          LF_TRIM_LSB   = 2;
  localparam int          LF_DIV_LSB    = 0;
  localparam int          PWR_FLAG_LSB  = 2;
  localparam int          PWR_STOP_BIT  = 1;
  localparam int          PWR_IDLE_BIT  = 0;
  localparam int          XO_VALID_BIT  = 7;
  localparam int          XO_MODE_LSB   = 4;
  localparam int          XO_DRV_LSB    = 0;
  localparam int          FL_ONESHOT_BIT = 7;
  localparam int          FL_RDTIME_BIT = 4;
  localparam int          IRQ_N         = 3;

  // Reset values.
  localparam logic [3:0]  LF_TRIM_RST   = 4'h8;
  localparam logic [5:0]  PWR_FLAG_RST  = 6'h00;
  localparam logic [7:0]  EXT_OSC_RST   = 8'h00;
  localparam logic [7:0]  FL_SCALE_RST  = 8'h80;
  localparam logic [2:0]  IRQ_MASK_RST  = 3'h0;

  // Encodings.
  localparam logic [2:0]  XO_MODE_CMOS  = 3'h2;
  localparam logic [1:0]  XO_MODE_XTAL  = 2'h3;

  // Timing counts in system clock cycles.
  localparam int          LF_BASE_CYC   = 16;
  localparam int          LF_TRIM_STEP  = 4;
  localparam int          LF_SETTLE_CYC = 64;
  localparam int          FL_SHORT_CYC  = 1;
  localparam int          FL_LONG_CYC   = 2;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } oft_axi_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } oft_axi_rsp_t;

endpackage

// ==== rtl/oft_lf_osc.sv ====
// Low-frequency oscillator model: a trimmed period counter on the system
// clock, a settle counter behind the ready flag and a post-divider.
module oft_lf_osc #(
  parameter int BASE_CYC   = oft_pkg::LF_BASE_CYC,
  parameter int TRIM_STEP  = oft_pkg::LF_TRIM_STEP,
  parameter int SETTLE_CYC = oft_pkg::LF_SETTLE_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       enable,
  input  wire logic [3:0] trim,
  input  wire logic [1:0] divSel,
  output logic            ready,
  output logic            lfTick
);

  localparam int PER_MAX = BASE_CYC + 15 * TRIM_STEP;

  if (BASE_CYC < 1 || TRIM_STEP < 0 || SETTLE_CYC < 1) begin : g_chk
    $error("oft_lf_osc: counts must be positive");
  end

  logic [15:0] phase_q, phase_d;
  logic [15:0] settle_q, settle_d;
  logic [2:0]  div_q, div_d;
  logic [15:0] period;
  logic [2:0]  mask;
  logic        rawTick;

  // Larger trim codes lengthen the period, so 0000b is fastest.
  always_comb begin
    period  = 16'(BASE_CYC) + 16'(trim) * 16'(TRIM_STEP);   // see (RQ3)
    rawTick = enable && (phase_q >= period - 16'h0001);
    unique case (divSel)                                     // see (RQ4)
      2'h0: mask = 3'h7;
      2'h1: mask = 3'h3;
      2'h2: mask = 3'h1;
      2'h3: mask = 3'h0;
    endcase
    lfTick   = rawTick && ((div_q & mask) == mask);
    phase_d  = (!enable || rawTick) ? 16'h0000 : phase_q + 16'h0001;
    div_d    = !enable ? 3'h0 : (rawTick ? div_q + 3'h1 : div_q);
    // Ready only after the oscillator ran for the settle time.
    settle_d = !enable ? 16'h0000 :                          // see (RQ1)
               (settle_q == 16'(SETTLE_CYC)) ? settle_q :
               settle_q + 16'h0001;
    ready    = enable && (settle_q == 16'(SETTLE_CYC));      // see (RQ2)
  end

  // State registers.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phase_q  <= 16'h0000;
      settle_q <= 16'h0000;
      div_q    <= 3'h0;
    end else begin
      phase_q  <= phase_d;
      settle_q <= settle_d;
      div_q    <= div_d;
    end
  end

  if (PER_MAX > 65535) begin : g_chk2
    $error("oft_lf_osc: period does not fit");
  end

endmodule // oft_lf_osc

// ==== rtl/oft_flash_rd.sv ====
// Flash read timing: one access lasts a short or a long count of cycles;
// the sense enable spans it all, or only its first cycle in one-shot mode.
module oft_flash_rd #(
  parameter int SHORT_CYC = oft_pkg::FL_SHORT_CYC,
  parameter int LONG_CYC  = oft_pkg::FL_LONG_CYC
) (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic rdReq,
  input  wire logic oneShotEn,
  input  wire logic longRead,
  output logic      senseEn,
  output logic      rdBusy,
  output logic      rdDone
);

  if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC || LONG_CYC > 15) begin : g_chk
    $error("oft_flash_rd: bad read cycle counts");
  end

  logic [3:0] left_q, left_d;
  logic       first_q, first_d;

  // A request while busy is ignored; the CPU issues one read at a time.
  always_comb begin
    left_d  = left_q;
    first_d = 1'b0;
    rdBusy  = (left_q != 4'h0);
    rdDone  = (left_q == 4'h1);
    if (rdBusy) begin
      left_d = left_q - 4'h1;
    end else if (rdReq) begin
      left_d  = longRead ? 4'(LONG_CYC) : 4'(SHORT_CYC);    // see (RQ8)
      first_d = 1'b1;
    end
    senseEn = rdBusy && (!oneShotEn || first_q);             // see (RQ6)
  end

  // State registers.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      left_q  <= 4'h0;
      first_q <= 1'b0;
    end else begin
      left_q  <= left_d;
      first_q <= first_d;
    end
  end

endmodule // oft_flash_rd

// ==== tb/oft_clk_ctrl_sva.sv ====
// Checker on the top ports; every relation is sampled on the system clock.
module oft_clk_ctrl_chk (
  input wire logic                  clk_sys,
  input wire logic                  arst_n,
  input wire oft_pkg::oft_axi_req_t axiReq,
  input wire oft_pkg::oft_axi_rsp_t axiRsp,
  input wire logic                  wakeReq,
  input wire logic                  flashRdReq,
  input wire logic                  cpuClkEn,
  input wire logic                  intOscRun,
  input wire logic                  lfTick,
  input wire logic                  flashSenseEn,
  input wire logic                  flashRdBusy,
  input wire logic                  flashRdDone
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // Sense amplifiers left on outside a read would only burn power.
  a_sense_in_read: assert property (
    flashSenseEn |-> flashRdBusy) else $error("sense enable outside read");
  a_read_start: assert property (
    flashRdReq && !flashRdBusy |=> flashRdBusy)
    else $error("flash read not started");
  a_done_ends_read: assert property (
    flashRdDone && !flashRdReq |=> !flashRdBusy && !flashRdDone)
    else $error("flash read outlives done");
  a_stop_gates_cpu: assert property (
    !intOscRun |-> !cpuClkEn) else $error("cpu clock runs in stop");
  a_wake_resumes: assert property (
    wakeReq |=> cpuClkEn && intOscRun) else $error("wake not honoured");
  // The shortest divided period is sixteen cycles, so a tick is isolated.
  a_tick_spacing: assert property (
    lfTick |=> !lfTick [*8]) else $error("ticks too close");
  a_bresp_holds: assert property (
    axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp))
    else $error("write response dropped");
  a_rdata_holds: assert property (
    axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata))
    else $error("read data dropped");
  a_read_answer: assert property (
    axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read not answered");

  // Main scenarios reached by the bench.
  c_long_read: cover property (flashRdBusy [*2]);
  c_stop_wake: cover property (!intOscRun ##[1:20] wakeReq);
  c_tick: cover property (lfTick);
endmodule // oft_clk_ctrl_chk

// ==== tb/oft_clk_ctrl_bench.sv ====
module oft_clk_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [11:0] A_LF   = 12'({oft_pkg::IDX_LF_OSC, 2'b00});
  localparam logic [11:0] A_PWR  = 12'({oft_pkg::IDX_PWR, 2'b00});
  localparam logic [11:0] A_EXT  = 12'({oft_pkg::IDX_EXT_OSC, 2'b00});
  localparam logic [11:0] A_FL   = 12'({oft_pkg::IDX_FL_SCALE, 2'b00});
  localparam logic [11:0] A_STAT = 12'({oft_pkg::IDX_IRQ_STAT, 2'b00});
  localparam logic [11:0] A_MASK = 12'({oft_pkg::IDX_IRQ_MASK, 2'b00});

  logic                  clk_sys    = 1'b0;
  logic                  arst_n     = 1'b0;
  logic                  xtalStable = 1'b0;
  logic                  wakeReq    = 1'b0;
  logic                  flashRdReq = 1'b0;
  oft_pkg::oft_axi_req_t axiReq     = '0;
  oft_pkg::oft_axi_rsp_t axiRsp;
  logic                  irq;
  logic                  cpuClkEn;
  logic                  intOscRun;
  logic                  lfTick;
  logic [3:0]            lfTrim;
  logic                  extCmosMode;
  logic [2:0]            extDriveSel;
  logic                  flashSenseEn;
  logic                  flashRdBusy;
  logic                  flashRdDone;
  int                    miscompares = 0;
  int                    compares    = 0;

  oft_clk_ctrl u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .axiReq(axiReq), .axiRsp(axiRsp),
    .xtalStable(xtalStable), .wakeReq(wakeReq), .flashRdReq(flashRdReq),
    .irq(irq), .cpuClkEn(cpuClkEn), .intOscRun(intOscRun), .lfTick(lfTick),
    .lfTrim(lfTrim), .extCmosMode(extCmosMode), .extDriveSel(extDriveSel),
    .flashSenseEn(flashSenseEn), .flashRdBusy(flashRdBusy),
    .flashRdDone(flashRdDone)
  );

  // Free-running 100 MHz system clock.
  always #5 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Address and data are offered together and each is dropped once taken.
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    @(posedge clk_sys);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr  <= a;
    axiReq.wvalid  <= 1'b1;
    axiReq.wdata   <= {24'h0, d};
    axiReq.wstrb   <= 4'hF;
    axiReq.bready  <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid) begin
        r = axiRsp.bresp;
        axiReq.bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_sys);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr  <= a;
    axiReq.rready  <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid) begin
        d = axiRsp.rdata;
        r = axiRsp.rresp;
        axiReq.rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic wrOk(input logic [11:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk(32'(r), 32'(oft_pkg::RESP_OKAY));
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, {24'h0, e});
    chk(32'(r), 32'(oft_pkg::RESP_OKAY));
  endtask

  // Skips two ticks so a period cut short by reprogramming is not measured.
  task automatic tickGap(output int g);
    repeat (2) begin
      do @(posedge clk_sys); while (lfTick !== 1'b1);
    end
    g = 0;
    do begin
      @(posedge clk_sys);
      g++;
    end while (lfTick !== 1'b1);
  endtask

  task automatic wake();
    @(posedge clk_sys) wakeReq <= 1'b1;
    @(posedge clk_sys) wakeReq <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Main sequence.
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          nb, ns, nd, g;
    int          trims[4] = '{0, 15, 0, 0};
    int          divs[4]  = '{3, 3, 0, 2};
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    rdChk(A_PWR, 8'h00);
    rdChk(A_EXT, 8'h00);
    rdChk(A_FL, 8'h80);
    rdChk(A_MASK, 8'h00);
    rdChk(A_STAT, 8'h00);
    rd(12'h100, d, r);
    chk(32'(r), 32'(oft_pkg::RESP_SLVERR));
    chk(d, 32'h0);
    wr(12'h100, 8'hFF, r);
    chk(32'(r), 32'(oft_pkg::RESP_SLVERR));
    // Every one-shot and read-time combination.
    for (int i = 0; i < 4; i++) begin
      wrOk(A_FL, {i[1], 2'b00, i[0], 4'h0});
      rdChk(A_FL, {i[1], 2'b00, i[0], 4'h0});
      @(posedge clk_sys) flashRdReq <= 1'b1;
      @(posedge clk_sys) flashRdReq <= 1'b0;
      nb = 0;
      ns = 0;
      nd = 0;
      repeat (4) begin
        @(posedge clk_sys);
        nb += int'(flashRdBusy);
        ns += int'(flashSenseEn);
        nd += int'(flashRdDone);
      end
      chk(nb, i[0] ? 2 : 1);
      chk(ns, i[1] ? 1 : (i[0] ? 2 : 1));
      chk(nd, 1);
    end
    // The last pass leaves the one-shot on, as slow clocks would want it.
    rdChk(A_FL, 8'h90);
    // Oscillator settling, ready event and interrupt masking.
    rdChk(A_LF, 8'h20);
    wrOk(A_LF, 8'h83);
    rdChk(A_LF, 8'h83);
    repeat (70) @(posedge clk_sys);
    rdChk(A_LF, 8'hC3);
    rdChk(A_STAT, 8'h01);
    chk(32'(irq), 32'h0);
    wrOk(A_MASK, 8'h07);
    rdChk(A_MASK, 8'h07);
    @(posedge clk_sys);
    chk(32'(irq), 32'h1);
    wrOk(A_STAT, 8'h01);
    @(posedge clk_sys);
    chk(32'(irq), 32'h0);
    rdChk(A_STAT, 8'h00);
    // Trim and divider set the tick period.
    for (int i = 0; i < 4; i++) begin
      wrOk(A_LF, 8'(8'h80 | (trims[i] << 2) | divs[i]));
      chk(32'(lfTrim), trims[i]);
      tickGap(g);
      chk(g, (16 + 4 * trims[i]) * (8 >> divs[i]));
    end
    wrOk(A_LF, 8'h00);
    nb = 0;
    repeat (300) begin
      @(posedge clk_sys);
      nb += int'(lfTick);
    end
    chk(nb, 0);
    // External oscillator modes and the crystal flag.
    wrOk(A_EXT, 8'h2D);
    rdChk(A_EXT, 8'h25);
    chk(32'(extCmosMode), 32'h1);
    chk(32'(extDriveSel), 32'h5);
    @(posedge clk_sys) xtalStable <= 1'b1;
    wrOk(A_EXT, 8'h65);
    repeat (4) @(posedge clk_sys);
    rdChk(A_EXT, 8'hE5);
    chk(32'(extCmosMode), 32'h0);
    wrOk(A_EXT, 8'h25);
    rdChk(A_EXT, 8'h25);
    rdChk(A_STAT, 8'h02);
    wrOk(A_STAT, 8'h02);
    // Stop and idle, each ended by a wake request.
    // Stop and idle are written together here, so stop has to win.
    wrOk(A_PWR, 8'hFF);
    @(posedge clk_sys);
    chk(32'({cpuClkEn, intOscRun}), 32'h0);
    wake();
    chk(32'({cpuClkEn, intOscRun}), 32'h3);
    rdChk(A_PWR, 8'hFC);
    wrOk(A_PWR, 8'h01);
    @(posedge clk_sys);
    chk(32'({cpuClkEn, intOscRun}), 32'h1);
    wake();
    chk(32'({cpuClkEn, intOscRun}), 32'h3);
    rdChk(A_PWR, 8'h00);
    rdChk(A_STAT, 8'h04);
    stop_test();
  end

  // Watchdog: the sequence needs well under 10000 cycles.
  initial begin
    #200us;
    miscompares++;
    stop_test();
  end
endmodule // oft_clk_ctrl_bench

bind oft_clk_ctrl oft_clk_ctrl_chk u_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .axiReq(axiReq), .axiRsp(axiRsp),
  .wakeReq(wakeReq), .flashRdReq(flashRdReq), .cpuClkEn(cpuClkEn),
  .intOscRun(intOscRun), .lfTick(lfTick), .flashSenseEn(flashSenseEn),
  .flashRdBusy(flashRdBusy), .flashRdDone(flashRdDone)
);
